/* File: rtl/bci_defs.svh */
// Constants for the bus command interpreter: characters, fields, resets, timing
`ifndef BCI_DEFS_SVH
`define BCI_DEFS_SVH

// Clock rate and documented display / scan times
`define BCI_CLK_HZ        32'd20000000
`define BCI_ERR_SHOW_MS   32'd1000
`define BCI_SEC_MS        32'd1000

// Characters of the command language
`define BCI_CH_EXEC       8'h58
`define BCI_CH_SPACE      8'h20
`define BCI_CH_DOT        8'h2E
`define BCI_CH_ZERO       8'h30
`define BCI_CH_NINE       8'h39
`define BCI_CH_POLE       8'h41
`define BCI_CH_BFMT       8'h42
`define BCI_CH_DISP       8'h44
`define BCI_CH_FIRST      8'h46
`define BCI_CH_PREFIX     8'h47
`define BCI_CH_EOI        8'h4B
`define BCI_CH_LAST       8'h4C
`define BCI_CH_SRQM       8'h4D
`define BCI_CH_SCANM      8'h50
`define BCI_CH_PROG       8'h51
`define BCI_CH_TRIG       8'h54
`define BCI_CH_ALT        8'h55
`define BCI_CH_INTV       8'h57
`define BCI_CH_TERM       8'h59

// Option limits
`define BCI_POLE_MAX      16'd1
`define BCI_DISP_MAX      16'd5
`define BCI_MAX_CHAN      16'd40
`define BCI_BYTE_MAX      16'd255
`define BCI_TRIG_MAX      16'd7
`define BCI_ALT_MAX       16'd8
`define BCI_MISC_MAX      16'd9
`define BCI_PROG_MAX      16'd99
`define BCI_PROG_LOCAL0   16'd3
`define BCI_PROG_LOCAL1   16'd90
`define BCI_PROG_LOCAL2   16'd91
`define BCI_PROG_LOCAL3   16'd92

// Mode codes
`define BCI_POLE_MATRIX   1'b0
`define BCI_DISP_CHAN     3'h0
`define BCI_DISP_MATRIX   3'h6
`define BCI_TRIG_ON_EXEC  3'h4
`define BCI_ALT_STATUS    4'h4
`define BCI_SRQ_ON_ERR    1

// Serial-poll status byte bits
`define BCI_SB_SRQ        6
`define BCI_SB_ERRSEL     5
`define BCI_SB_NOREM      2
`define BCI_SB_ILLEGAL_OPTION_ERROR      1
`define BCI_SB_ILLEGAL_COMMAND_ERROR       0

// Front-panel error message codes
`define BCI_EC_NONE       2'h0
`define BCI_EC_ILLEGAL_COMMAND_ERROR       2'h1
`define BCI_EC_ILLEGAL_OPTION_ERROR      2'h2
`define BCI_EC_NOREM      2'h3

// Reset values
`define BCI_RST_POLE      1'b1
`define BCI_RST_DISP      3'h0
`define BCI_RST_FIRST     8'h01
`define BCI_RST_LAST      8'h01
`define BCI_RST_INTV      8'h01
`define BCI_RST_SRQM      8'h00
`define BCI_RST_SRQSTAT   24'h303030
`define BCI_RST_TRIG      3'h0
`define BCI_RST_ALT       4'h0
`define BCI_RST_PROG      7'h00

`endif

/* File: rtl/bci_pkg.sv */
// Types of the bus command interpreter
package bci_pkg;

  typedef enum logic [1:0] {PS_IDLE, PS_ARG, PS_FRAC} bci_pstate_t;

  typedef struct packed {
    logic       pole;
    logic [2:0] disp;
    logic [7:0] first;
    logic [7:0] last;
    logic [7:0] intv;
    logic [7:0] srqMode;
    logic [2:0] trig;
    logic [3:0] alt;
    logic [6:0] prog;
  } bci_cfg_t;

  typedef struct packed {
    bci_pstate_t ps;
    logic [7:0]  curLetter;
    logic [15:0] argVal;
    logic        errCmd;
    logic        errOpt;
    logic        errRem;
    logic        gotA0;
    logic        gotD0;
    logic        gotU4;
    bci_cfg_t    shadow;
    bci_cfg_t    live;
    logic [7:0]  statusByte;
    logic        srqOut;
    logic [23:0] srqStatus;
    logic        sendStatusWord;
    logic        dispErr;
    logic [1:0]  dispErrCode;
    logic [24:0] errTimer;
    logic        scanActive;
    logic [7:0]  curChan;
    logic        chanStep;
    logic [24:0] secCnt;
    logic [7:0]  intvCnt;
    logic        trigPrev;
  } bci_state_t;

endpackage : bci_pkg

/* File: rtl/bci_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bci_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
          stage3_r[i] <= 1'b0;
          pinSync[i]  <= 1'b0;
        end else begin
          stage1_r[i] <= pinIn[i];
          stage2_r[i] <= stage1_r[i];
          stage3_r[i] <= stage2_r[i];
          // A change counts only once the second and third stages agree
          if (stage2_r[i] == stage3_r[i]) begin
            pinSync[i] <= stage3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule : bci_sync
`default_nettype wire

/* File: rtl/bci_top.sv */
// Bus command interpreter: parses command strings, reports errors, runs the scan
// Summary of operation
// - SRQ status is three digits of mode
// - Pole select beats display select; matrix display
// - Programs 3, 90, 91, 92 are local-only
// - Any error discards the whole string
// - Rejection sets status byte error bits
// - SRQ on error only when enabled
// - Several commands per string; spaces ignored
// - Decimal argument, fraction dropped, absent is zero
// - Unknown letter raises illegal-command error
// - Out-of-range argument raises illegal-option error
// - Error message shown about one second
// - Command outside remote mode gives no-remote error
// - Scan first to last, one per interval
// - Bit six SRQ, bit five selects error meaning
// - Status word replaces data on next talk
`include "bci_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bci_top #(
  parameter int ERR_SHOW_CYCLES = int'(`BCI_ERR_SHOW_MS * (`BCI_CLK_HZ / 32'd1000)),
  parameter int SEC_CYCLES      = int'(`BCI_SEC_MS * (`BCI_CLK_HZ / 32'd1000))
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        charValid,
  input  wire logic [7:0]  charData,
  input  wire logic        remotePin,
  input  wire logic        trigPin,
  input  wire logic        spollDone,
  input  wire logic        talkDone,
  output var  logic [7:0]  statusByte,
  output var  logic        srqOut,
  output var  logic [23:0] srqStatus,
  output var  logic        sendStatusWord,
  output var  logic [3:0]  altOutputSel,
  output var  logic        dispErr,
  output var  logic [1:0]  dispErrCode,
  output var  logic [2:0]  dispMode,
  output var  logic        poleMode,
  output var  logic [6:0]  progSel,
  output var  logic [7:0]  firstChan,
  output var  logic [7:0]  lastChan,
  output var  logic [7:0]  intervalSec,
  output var  logic [7:0]  curChan,
  output var  logic        scanActive,
  output var  logic        chanStep
);
  localparam bci_pkg::bci_cfg_t CFG_RST = '{
    pole: `BCI_RST_POLE, disp: `BCI_RST_DISP, first: `BCI_RST_FIRST,
    last: `BCI_RST_LAST, intv: `BCI_RST_INTV, srqMode: `BCI_RST_SRQM,
    trig: `BCI_RST_TRIG, alt: `BCI_RST_ALT, prog: `BCI_RST_PROG};
  localparam logic [24:0] ERR_LOAD = 25'(ERR_SHOW_CYCLES - 1);
  localparam logic [24:0] SEC_LAST = 25'(SEC_CYCLES - 1);

  bci_pkg::bci_state_t r;
  bci_pkg::bci_state_t n;
  logic [1:0]          pinSync;

  bci_sync #(
    .WIDTH   (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   ({remotePin, trigPin}),
    .pinSync (pinSync)
  );

  function automatic logic isCmd(input logic [7:0] c);
    case (c)
      `BCI_CH_POLE, `BCI_CH_BFMT, `BCI_CH_DISP, `BCI_CH_FIRST, `BCI_CH_PREFIX,
      `BCI_CH_EOI, `BCI_CH_LAST, `BCI_CH_SRQM, `BCI_CH_SCANM, `BCI_CH_PROG,
      `BCI_CH_TRIG, `BCI_CH_ALT, `BCI_CH_INTV, `BCI_CH_TERM: isCmd = 1'b1;
      default: isCmd = 1'b0;
    endcase
  endfunction : isCmd

  // Whether the argument lies in the option set of its command
  function automatic logic optLegal(input logic [7:0] c, input logic [15:0] a);
    case (c)
      `BCI_CH_POLE:  optLegal = (a <= `BCI_POLE_MAX);
      `BCI_CH_DISP:  optLegal = (a <= `BCI_DISP_MAX);
      `BCI_CH_FIRST,
      `BCI_CH_LAST:  optLegal = (a != 16'h0000) && (a <= `BCI_MAX_CHAN);
      `BCI_CH_INTV:  optLegal = (a != 16'h0000) && (a <= `BCI_BYTE_MAX);
      `BCI_CH_SRQM:  optLegal = (a <= `BCI_BYTE_MAX);
      `BCI_CH_TRIG:  optLegal = (a <= `BCI_TRIG_MAX);
      `BCI_CH_ALT:   optLegal = (a <= `BCI_ALT_MAX);
      `BCI_CH_PROG:  optLegal = (a <= `BCI_PROG_MAX) && (a != `BCI_PROG_LOCAL0) &&
                                (a != `BCI_PROG_LOCAL1) && (a != `BCI_PROG_LOCAL2) &&
                                (a != `BCI_PROG_LOCAL3);
      default:       optLegal = (a <= `BCI_MISC_MAX);
    endcase
  endfunction : optLegal

  function automatic bci_pkg::bci_cfg_t applyCmd(input bci_pkg::bci_cfg_t cfg,
                                                 input logic [7:0] c,
                                                 input logic [15:0] a);
    bci_pkg::bci_cfg_t res;
    res = cfg;
    case (c)
      `BCI_CH_POLE:  res.pole    = a[0];
      `BCI_CH_DISP:  res.disp    = a[2:0];
      `BCI_CH_FIRST: res.first   = a[7:0];
      `BCI_CH_LAST:  res.last    = a[7:0];
      `BCI_CH_INTV:  res.intv    = a[7:0];
      `BCI_CH_SRQM:  res.srqMode = a[7:0];
      `BCI_CH_TRIG:  res.trig    = a[2:0];
      `BCI_CH_ALT:   res.alt     = a[3:0];
      `BCI_CH_PROG:  res.prog    = a[6:0];
      default:       res         = cfg;
    endcase
    applyCmd = res;
  endfunction : applyCmd

  // Three ASCII decimal digits of a byte
  function automatic logic [23:0] toDigits(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] u;
    h = v / 8'd100;
    t = (v % 8'd100) / 8'd10;
    u = v % 8'd10;
    toDigits = {`BCI_CH_ZERO + h, `BCI_CH_ZERO + t, `BCI_CH_ZERO + u};
  endfunction : toDigits

  always_comb begin
    logic              remote;
    logic              trigEdge;
    logic              eCmd;
    logic              eOpt;
    logic              eRem;
    logic              a0;
    logic              d0;
    logic              u4;
    logic [20:0]       acc;
    bci_pkg::bci_cfg_t sh;
    remote   = pinSync[1];
    trigEdge = pinSync[0] && !r.trigPrev;
    eCmd     = r.errCmd;
    eOpt     = r.errOpt;
    eRem     = r.errRem;
    a0       = r.gotA0;
    d0       = r.gotD0;
    u4       = r.gotU4;
    sh       = r.shadow;
    acc      = 21'h000000;
    n          = r;
    n.chanStep = 1'b0;
    n.trigPrev = pinSync[0];

    // Flags cleared by the controller; a new setting later in the cycle wins
    if (spollDone) begin
      n.statusByte = 8'h00;
      n.srqOut     = 1'b0;
    end
    if (talkDone) begin
      n.sendStatusWord = 1'b0;
    end

    if (charValid) begin
      if (!remote) begin
        eRem = 1'b1;
      end
      if (charData == `BCI_CH_SPACE) begin
        n.ps = r.ps;
      end else if (charData >= `BCI_CH_ZERO && charData <= `BCI_CH_NINE) begin
        if (r.ps == bci_pkg::PS_ARG) begin
          acc = {5'h00, r.argVal} * 21'd10 + {17'h00000, charData[3:0]};
          n.argVal = (|acc[20:16]) ? 16'hFFFF : acc[15:0];
        end else if (r.ps == bci_pkg::PS_IDLE) begin
          eCmd = 1'b1;
        end
      end else if (charData == `BCI_CH_DOT) begin
        if (r.ps == bci_pkg::PS_ARG) begin
          n.ps = bci_pkg::PS_FRAC;
        end else if (r.ps == bci_pkg::PS_IDLE) begin
          eCmd = 1'b1;
        end
      end else begin
        // Any other character closes the pending command first
        if (r.ps != bci_pkg::PS_IDLE) begin
          if (!optLegal(r.curLetter, r.argVal)) begin
            eOpt = 1'b1;
          end
          if (r.curLetter == `BCI_CH_POLE && r.argVal == 16'h0000) begin
            a0 = 1'b1;
          end
          if (r.curLetter == `BCI_CH_DISP && r.argVal == 16'h0000) begin
            d0 = 1'b1;
          end
          if (r.curLetter == `BCI_CH_ALT && r.argVal == 16'(`BCI_ALT_STATUS)) begin
            u4 = 1'b1;
          end
          sh = applyCmd(sh, r.curLetter, r.argVal);
        end
        n.ps     = bci_pkg::PS_IDLE;
        n.argVal = 16'h0000;
        if (charData == `BCI_CH_EXEC) begin
          if (!(eCmd || eOpt || eRem)) begin
            if (a0 && d0 && sh.pole == `BCI_POLE_MATRIX &&
                sh.disp == `BCI_DISP_CHAN) begin
              sh.disp = `BCI_DISP_MATRIX;
            end
            n.live = sh;
            if (u4) begin
              n.sendStatusWord = 1'b1;
            end
            if (sh.trig == `BCI_TRIG_ON_EXEC) begin
              n.scanActive = 1'b1;
              n.curChan    = sh.first;
              n.chanStep   = 1'b1;
              n.secCnt     = 25'h0000000;
              n.intvCnt    = 8'h00;
            end
          end else begin
            // Nothing from the string is kept
            sh = r.live;
            n.statusByte[`BCI_SB_ERRSEL] = 1'b1;
            n.statusByte[`BCI_SB_ILLEGAL_COMMAND_ERROR]   = n.statusByte[`BCI_SB_ILLEGAL_COMMAND_ERROR] | eCmd;
            n.statusByte[`BCI_SB_ILLEGAL_OPTION_ERROR]  = n.statusByte[`BCI_SB_ILLEGAL_OPTION_ERROR] | eOpt;
            n.statusByte[`BCI_SB_NOREM]  = n.statusByte[`BCI_SB_NOREM] | eRem;
            if (r.live.srqMode[`BCI_SRQ_ON_ERR]) begin
              n.statusByte[`BCI_SB_SRQ] = 1'b1;
              n.srqOut                  = 1'b1;
            end
            n.dispErr  = 1'b1;
            n.errTimer = ERR_LOAD;
            if (eRem) begin
              n.dispErrCode = `BCI_EC_NOREM;
            end else if (eCmd) begin
              n.dispErrCode = `BCI_EC_ILLEGAL_COMMAND_ERROR;
            end else begin
              n.dispErrCode = `BCI_EC_ILLEGAL_OPTION_ERROR;
            end
          end
          sh   = n.live;
          eCmd = 1'b0;
          eOpt = 1'b0;
          eRem = 1'b0;
          a0   = 1'b0;
          d0   = 1'b0;
          u4   = 1'b0;
        end else if (isCmd(charData)) begin
          n.curLetter = charData;
          n.ps        = bci_pkg::PS_ARG;
        end else begin
          eCmd = 1'b1;
        end
      end
    end
    n.shadow = sh;
    n.errCmd = eCmd;
    n.errOpt = eOpt;
    n.errRem = eRem;
    n.gotA0  = a0;
    n.gotD0  = d0;
    n.gotU4  = u4;
    n.srqStatus = toDigits(n.live.srqMode);

    // Error message timer; on expiry the normal display returns
    if (r.dispErr && !(n.dispErr && n.errTimer == ERR_LOAD && r.errTimer != ERR_LOAD)) begin
      if (r.errTimer == 25'h0000000) begin
        n.dispErr     = 1'b0;
        n.dispErrCode = `BCI_EC_NONE;
      end else if (n.errTimer == r.errTimer) begin
        n.errTimer = r.errTimer - 25'h0000001;
      end
    end

    // External trigger starts a scan when not triggered by execute
    if (trigEdge && !n.scanActive && n.live.trig != `BCI_TRIG_ON_EXEC) begin
      n.scanActive = 1'b1;
      n.curChan    = n.live.first;
      n.chanStep   = 1'b1;
      n.secCnt     = 25'h0000000;
      n.intvCnt    = 8'h00;
    end else if (r.scanActive && !n.chanStep) begin
      if (r.secCnt == SEC_LAST) begin
        n.secCnt = 25'h0000000;
        if (r.intvCnt + 8'h01 >= r.live.intv) begin
          n.intvCnt = 8'h00;
          if (r.curChan >= r.live.last) begin
            n.scanActive = 1'b0;
          end else begin
            n.curChan  = r.curChan + 8'h01;
            n.chanStep = 1'b1;
          end
        end else begin
          n.intvCnt = r.intvCnt + 8'h01;
        end
      end else begin
        n.secCnt = r.secCnt + 25'h0000001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{ps: bci_pkg::PS_IDLE, shadow: CFG_RST, live: CFG_RST,
             dispErrCode: `BCI_EC_NONE, srqStatus: `BCI_RST_SRQSTAT, default: '0};
    end else begin
      r <= n;
    end
  end

  assign statusByte     = r.statusByte;
  assign srqOut         = r.srqOut;
  assign srqStatus      = r.srqStatus;
  assign sendStatusWord = r.sendStatusWord;
  assign altOutputSel   = r.live.alt;
  assign dispErr        = r.dispErr;
  assign dispErrCode    = r.dispErrCode;
  assign dispMode       = r.live.disp;
  assign poleMode       = r.live.pole;
  assign progSel        = r.live.prog;
  assign firstChan      = r.live.first;
  assign lastChan       = r.live.last;
  assign intervalSec    = r.live.intv;
  assign curChan        = r.curChan;
  assign scanActive     = r.scanActive;
  assign chanStep       = r.chanStep;
endmodule : bci_top
`default_nettype wire

/* File: verification/bci_top_asserts.sv */
// Port-level concurrent checks for the bus command interpreter
`timescale 1ns/1ps
`default_nettype none
module bci_top_asserts #(
  parameter int ERR_SHOW_CYCLES = 50
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        charValid,
  input wire logic        spollDone,
  input wire logic        talkDone,
  input wire logic [7:0]  statusByte,
  input wire logic        srqOut,
  input wire logic [23:0] srqStatus,
  input wire logic        sendStatusWord,
  input wire logic        dispErr,
  input wire logic [1:0]  dispErrCode,
  input wire logic [2:0]  dispMode,
  input wire logic        poleMode,
  input wire logic [7:0]  firstChan,
  input wire logic [7:0]  lastChan,
  input wire logic [7:0]  curChan,
  input wire logic        scanActive,
  input wire logic        chanStep
);
  logic [31:0] showCnt_r;
  logic [31:0] showCnt_nxt;

  // Length of the current error message display
  always_comb showCnt_nxt = dispErr ? showCnt_r + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) begin
    if (reset) showCnt_r <= 32'h0;
    else showCnt_r <= showCnt_nxt;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_srq_digits: assert property (srqStatus[23:16] inside {[8'h30:8'h32]}
    && srqStatus[15:8] inside {[8'h30:8'h39]} && srqStatus[7:0] inside {[8'h30:8'h39]})
    else $error("service request status is not three decimal digits");
  chk_srq_mirror: assert property (srqOut == statusByte[6])
    else $error("service request line and status bit six disagree");
  chk_err_select: assert property ((|statusByte[2:0]) |-> statusByte[5])
    else $error("error bits set without the error select bit");
  chk_poll_clear: assert property (spollDone && !charValid |=> statusByte == 8'h00 && !srqOut)
    else $error("serial poll did not clear the status byte");
  chk_talk_clear: assert property (talkDone && !charValid |=> !sendStatusWord)
    else $error("talk did not clear the status word request");
  chk_show_bound: assert property (showCnt_r <= ERR_SHOW_CYCLES)
    else $error("error message shown too long");
  chk_show_len: assert property ($fell(dispErr) |-> showCnt_r == ERR_SHOW_CYCLES)
    else $error("error message display time wrong");
  chk_err_code: assert property (dispErr |-> dispErrCode != 2'h0)
    else $error("error message shown without a code");
  chk_step_range: assert property (chanStep |-> scanActive && curChan >= firstChan
    && curChan <= lastChan) else $error("scan step outside the programmed channels");
  chk_step_pulse: assert property (chanStep |=> !chanStep)
    else $error("channel step longer than one cycle");
  chk_cfg_commit: assert property ($changed(dispMode) || $changed(poleMode)
    || $changed(firstChan) |-> $past(charValid)) else $error("setting changed without a string");
endmodule : bci_top_asserts

bind bci_top bci_top_asserts #(.ERR_SHOW_CYCLES(ERR_SHOW_CYCLES)) CHK (
  .ref_clk(ref_clk), .reset(reset), .charValid(charValid), .spollDone(spollDone),
  .talkDone(talkDone), .statusByte(statusByte), .srqOut(srqOut), .srqStatus(srqStatus),
  .sendStatusWord(sendStatusWord), .dispErr(dispErr), .dispErrCode(dispErrCode),
  .dispMode(dispMode), .poleMode(poleMode), .firstChan(firstChan), .lastChan(lastChan),
  .curChan(curChan), .scanActive(scanActive), .chanStep(chanStep));
`default_nettype wire

/* File: verification/bci_ctrl_model.sv */
// Bus controller model: sends command strings, serial polls and talk cycles
`timescale 1ns/1ps
`default_nettype none
module bci_ctrl_model (
  input  wire logic       ref_clk,
  output var  logic       charValid,
  output var  logic [7:0] charData,
  output var  logic       spollDone,
  output var  logic       talkDone
);
  initial begin
    charValid = 1'b0;
    charData  = 8'hA5;
    spollDone = 1'b0;
    talkDone  = 1'b0;
  end

  // One character per cycle, back to back; data is scrambled while idle
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge ref_clk);
      charValid <= 1'b1;
      charData  <= s[i];
    end
    @(posedge ref_clk);
    charValid <= 1'b0;
    charData  <= ~charData;
  endtask : send

  task automatic spoll();
    @(posedge ref_clk);
    spollDone <= 1'b1;
    @(posedge ref_clk);
    spollDone <= 1'b0;
  endtask : spoll

  // Read right after the request so the front panel cannot alter it
  task automatic talk();
    @(posedge ref_clk);
    talkDone <= 1'b1;
    @(posedge ref_clk);
    talkDone <= 1'b0;
  endtask : talk
endmodule : bci_ctrl_model
`default_nettype wire

/* File: verification/test_bus_command_interpreter.sv */
// Self-checking testbench of the bus command interpreter
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_bus_command_interpreter;
  logic        ref_clk, reset, remotePin, trigPin;
  logic        charValid, spollDone, talkDone, srqOut, sendStatusWord, dispErr;
  logic        poleMode, scanActive, chanStep;
  logic [7:0]  charData, statusByte, firstChan, lastChan, intervalSec, curChan;
  logic [23:0] srqStatus;
  logic [3:0]  altOutputSel;
  logic [2:0]  dispMode;
  logic [1:0]  dispErrCode;
  logic [6:0]  progSel;
  int          checks, bad_count;

  bci_ctrl_model CTRL (.ref_clk(ref_clk), .charValid(charValid), .charData(charData),
    .spollDone(spollDone), .talkDone(talkDone));
  bci_top #(.ERR_SHOW_CYCLES(50), .SEC_CYCLES(20)) DUT (.ref_clk(ref_clk), .reset(reset),
    .charValid(charValid), .charData(charData), .remotePin(remotePin), .trigPin(trigPin),
    .spollDone(spollDone), .talkDone(talkDone), .statusByte(statusByte), .srqOut(srqOut),
    .srqStatus(srqStatus), .sendStatusWord(sendStatusWord), .altOutputSel(altOutputSel),
    .dispErr(dispErr), .dispErrCode(dispErrCode), .dispMode(dispMode), .poleMode(poleMode),
    .progSel(progSel), .firstChan(firstChan), .lastChan(lastChan),
    .intervalSec(intervalSec), .curChan(curChan), .scanActive(scanActive),
    .chanStep(chanStep));

  always #25 ref_clk = ~ref_clk;

  task automatic cmd(input string s);
    CTRL.send(s);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : cmd

  // Let the message run out, then poll the status byte clear
  task automatic drain();
    int n;
    n = 0;
    while (dispErr === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    CTRL.spoll();
    @(posedge ref_clk);
    #1;
    `TB_CHK(statusByte, 8'h00)
    `TB_CHK(dispErr, 1'b0)
  endtask : drain

  task automatic t_reset();
    `TB_CHK({poleMode, firstChan, lastChan, intervalSec}, 25'h1010101)
    `TB_CHK({statusByte, srqStatus, dispMode, progSel}, 42'h000C0C0C000)
    `TB_CHK({curChan, scanActive, sendStatusWord, altOutputSel}, 14'h0000)
    $display("test reset done");
  endtask : t_reset

  task automatic t_parse();
    cmd("F2Q1B2 X");
    `TB_CHK({firstChan, progSel}, 15'h0101)
    cmd("W003.000X");
    `TB_CHK(intervalSec, 8'h03)
    cmd("QX");
    `TB_CHK(progSel, 7'h00)
    $display("test parse done");
  endtask : t_parse

  task automatic t_errors();
    cmd("F7@0X");
    `TB_CHK({statusByte, dispErr, dispErrCode}, 11'h10D)
    `TB_CHK(firstChan, 8'h02)
    drain();
    cmd("F5D6X");
    `TB_CHK({statusByte, dispErrCode}, 10'h08A)
    `TB_CHK(firstChan, 8'h02)
    drain();
    $display("test errors done");
  endtask : t_errors

  task automatic t_local();
    int progs[4] = '{3, 90, 91, 92};
    foreach (progs[i]) begin
      cmd($sformatf("Q%0dX", progs[i]));
      `TB_CHK({statusByte, progSel}, 15'h1100)
      drain();
    end
    cmd("Q5X");
    `TB_CHK(progSel, 7'h05)
    $display("test local done");
  endtask : t_local

  task automatic t_srq();
    cmd("M2X");
    `TB_CHK(srqStatus, 24'h303032)
    cmd("D6X");
    `TB_CHK({statusByte, srqOut}, 9'h0C5)
    drain();
    `TB_CHK(srqOut, 1'b0)
    cmd("M0X");
    `TB_CHK(srqStatus, 24'h303030)
    $display("test srq done");
  endtask : t_srq

  task automatic t_norem();
    @(posedge ref_clk);
    remotePin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmd("D1X");
    `TB_CHK({statusByte, dispErrCode, dispMode}, 13'h0498)
    @(posedge ref_clk);
    remotePin <= 1'b1;
    drain();
    repeat (6) @(posedge ref_clk);
    $display("test noremote done");
  endtask : t_norem

  task automatic t_modes();
    cmd("A0D0X");
    `TB_CHK({poleMode, dispMode}, 4'h6)
    cmd("A1D2U4X");
    `TB_CHK({poleMode, dispMode, altOutputSel}, 8'hA4)
    `TB_CHK(sendStatusWord, 1'b1)
    CTRL.talk();
    @(posedge ref_clk);
    #1;
    `TB_CHK(sendStatusWord, 1'b0)
    $display("test modes done");
  endtask : t_modes

  task automatic t_scan();
    int n;
    CTRL.send("F1L3W1T4X");
    #1;
    `TB_CHK({chanStep, scanActive, curChan}, 10'h301)
    for (int ch = 2; ch <= 3; ch++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (chanStep !== 1'b1 && n < 100);
      `TB_CHK({scanActive, curChan}, 9'(ch) | 9'h100)
      `TB_CHK(n, 20)
    end
    n = 0;
    while (scanActive === 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    `TB_CHK({scanActive, curChan}, 9'h003)
    cmd("F4L4T0X");
    @(posedge ref_clk);
    trigPin <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (chanStep !== 1'b1 && n < 50);
    `TB_CHK({scanActive, curChan}, 9'h104)
    @(posedge ref_clk);
    trigPin <= 1'b0;
    $display("test scan done");
  endtask : t_scan

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(20000 * 50);
    bad_count++;
    finish_test();
  end

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    remotePin = 1'b1;
    trigPin = 1'b0;
    checks = 0;
    bad_count = 0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    t_reset();
    t_parse();
    t_errors();
    t_local();
    t_srq();
    t_norem();
    t_modes();
    t_scan();
    finish_test();
  end
endmodule : test_bus_command_interpreter
`default_nettype wire
